/* File: common/radb_pkg.sv */
// Purpose: shared constants and carrier types for the right AGC debounce slice
// Assumes: registers are reached through an already decoded control-bus access
// Notes: all debounce counts are in sample periods of the converter sample clock
package radb_pkg;

    // ----------------------------------------------------------------
    // Register map, page zero
    // ----------------------------------------------------------------
    localparam logic [7:0] RADB_PAGE_ZERO = 8'h00;
    localparam logic [6:0] RADB_OFF_NOISE_DEB = 7'h63;
    localparam logic [6:0] RADB_OFF_SIGNAL_DEB = 7'h64;
    localparam logic [6:0] RADB_OFF_GAIN_STAT = 7'h65;
    localparam logic [6:0] RADB_OFF_RSVD_FIRST = 7'h66;
    localparam logic [6:0] RADB_OFF_RSVD_LAST = 7'h7F;

    // ----------------------------------------------------------------
    // Field layouts and reset values
    // ----------------------------------------------------------------
    localparam int RADB_NOISE_CODE_W = 5;
    localparam int RADB_SIGNAL_CODE_W = 4;
    localparam logic [4:0] RADB_NOISE_CODE_RST = 5'h00;
    localparam logic [3:0] RADB_SIGNAL_CODE_RST = 4'h0;
    localparam logic [7:0] RADB_GAIN_STAT_RST = 8'h00;
    localparam logic [4:0] RADB_THRESH_OFF = 5'h00;

    // ----------------------------------------------------------------
    // Timing counts in sample periods
    // ----------------------------------------------------------------
    localparam int RADB_CNT_W = 17;
    localparam int RADB_NOISE_UNIT_SHIFT = 12;
    localparam int RADB_SIGNAL_UNIT_SHIFT = 11;
    localparam logic [4:0] RADB_NOISE_LONG_BASE = 5'h0A;
    localparam logic [4:0] RADB_NOISE_LONG_OFS = 5'h0A;
    localparam logic [4:0] RADB_NOISE_MIN_UNITS = 5'h02;
    localparam logic [3:0] RADB_SIGNAL_LONG_BASE = 4'hA;
    localparam logic [3:0] RADB_SIGNAL_LONG_OFS = 4'h8;

    // Gain status limits, half-dB steps, two's complement
    localparam logic [7:0] RADB_GAIN_MAX = 8'h50;
    localparam logic [7:0] RADB_GAIN_MIN = 8'hE8;

    // ----------------------------------------------------------------
    // Carrier types
    // ----------------------------------------------------------------
    typedef struct packed {
        logic       wr_en;
        logic       rd_en;
        logic [7:0] page;
        logic [6:0] addr;
        logic [7:0] wdata;
    } radb_req_t;

    typedef enum logic {
        RADB_ST_SIGNAL,
        RADB_ST_NOISE
    } radb_state_t;

endpackage

/* File: verilog/radb_debounce_timer.sv */
// Purpose: counts sample periods while a condition holds
// Assumes: i_tick is a one-cycle sample enable on i_mclk
// Notes: count restarts whenever the condition drops
`timescale 1ns/1ps
module radb_debounce_timer #(
    parameter int CNT_W = 17
) (
    input wire logic i_mclk,
    input wire logic i_srst,
    input wire logic i_run,
    input wire logic i_tick,
    input wire logic [CNT_W-1:0] i_target,
    output logic o_done
);

    logic [CNT_W-1:0] cnt_reg;

    // Saturating count of sample periods
    always_ff @(posedge i_mclk) begin
        if (i_srst || !i_run) begin
            cnt_reg <= '0;
        end else if (i_tick && (cnt_reg < i_target)) begin
            cnt_reg <= cnt_reg + 1'b1;
        end
    end

    // Done once the held time reaches the target
    assign o_done = i_run && (cnt_reg >= i_target);

endmodule

/* File: verilog/radb_top.sv */
// Purpose: right AGC noise and signal debounce settings and gain status
// Assumes: control-bus accesses arrive decoded, one per cycle, with page
// Notes: noise mode decision lives here; the gain loop is outside
//
// Function
// RULE1: Noise debounce is 5 bits; code 0 is none, codes 1 to 4 give 4, 8, 16, 32 periods.
// RULE2: Noise debounce code 7 gives 256 periods and code 10 gives twice 4096 periods.
// RULE3: Noise debounce codes 30 and 31 give 20 and 21 units of 4096 periods.
// RULE4: Signal debounce is 4 bits; code 0 is none, codes 1 to 4 give 4, 8, 16, 32 periods.
// RULE5: Signal debounce code 8 gives 1024 periods and code 9 gives 2048 periods.
// RULE6: Signal debounce code 13 gives five units of 2048, longer codes more units.
// RULE7: Gain status reports applied gain in half-dB steps, 0x50 meaning 40 dB.
// RULE8: Negative gains read in two's complement, 0xE8 meaning -12 dB.
// RULE9: Gain status is read-only, resets to zero, and ignores host writes.
// RULE10: Host writes reserved upper debounce bits only as zero.
// RULE11: Host never writes page zero locations 102 to 127.
// RULE12: A zero noise threshold turns detection off, so noise debounce does nothing.
// RULE13: Host selects page zero before touching these registers.
// RULE14: Noise mode is entered after the noise debounce time and left after the signal one.
`timescale 1ns/1ps
module radb_top (
    input wire logic i_mclk,
    input wire logic i_srst,
    input wire radb_pkg::radb_req_t i_req,
    input wire logic i_fs_tick,
    input wire logic i_below_thresh,
    input wire logic [4:0] i_noise_thresh,
    input wire logic [7:0] i_gain_applied,
    output logic [7:0] o_rd_data,
    output logic o_rd_valid,
    output logic o_noise_mode
);

    // ----------------------------------------------------------------
    // Decode functions
    // ----------------------------------------------------------------

    // Noise code to sample periods
    function automatic logic [16:0] noise_periods(input logic [4:0] code);
        logic [4:0] units;
        units = 5'h00;
        case (code)
            5'h00: noise_periods = 17'h0_0000;
            5'h01: noise_periods = 17'h0_0004;
            5'h02: noise_periods = 17'h0_0008;
            5'h03: noise_periods = 17'h0_0010;
            5'h04: noise_periods = 17'h0_0020;
            5'h05: noise_periods = 17'h0_0040;
            5'h06: noise_periods = 17'h0_0080;
            5'h07: noise_periods = 17'h0_0100;
            5'h08: noise_periods = 17'h0_0400;
            5'h09: noise_periods = 17'h0_0800;
            default: begin
                units = code - radb_pkg::RADB_NOISE_LONG_OFS;
                if (units < radb_pkg::RADB_NOISE_MIN_UNITS) begin
                    units = radb_pkg::RADB_NOISE_MIN_UNITS;
                end
                noise_periods = {units, 12'h000};
            end
        endcase
    endfunction

    // Signal code to sample periods
    function automatic logic [16:0] signal_periods(input logic [3:0] code);
        logic [3:0] units;
        units = 4'h0;
        case (code)
            4'h0: signal_periods = 17'h0_0000;
            4'h1: signal_periods = 17'h0_0004;
            4'h2: signal_periods = 17'h0_0008;
            4'h3: signal_periods = 17'h0_0010;
            4'h4: signal_periods = 17'h0_0020;
            4'h5: signal_periods = 17'h0_0040;
            4'h6: signal_periods = 17'h0_0080;
            4'h7: signal_periods = 17'h0_0200;
            4'h8: signal_periods = 17'h0_0400;
            4'h9: signal_periods = 17'h0_0800;
            default: begin
                units = code - radb_pkg::RADB_SIGNAL_LONG_OFS;
                signal_periods = {2'b00, units[2:0], 11'h000, 1'b0} >> 1;
            end
        endcase
    endfunction

    // Gain clamped to the reportable range
    function automatic logic [7:0] clamp_gain(input logic [7:0] g);
        if ($signed(g) > $signed(radb_pkg::RADB_GAIN_MAX)) begin
            clamp_gain = radb_pkg::RADB_GAIN_MAX;
        end else if ($signed(g) < $signed(radb_pkg::RADB_GAIN_MIN)) begin
            clamp_gain = radb_pkg::RADB_GAIN_MIN;
        end else begin
            clamp_gain = g;
        end
    endfunction

    // ----------------------------------------------------------------
    // Register file
    // ----------------------------------------------------------------
    logic [4:0] noise_code_reg;
    logic [3:0] signal_code_reg;
    logic [7:0] gain_stat_reg;
    logic page_ok;
    logic slice_hit;
    logic [7:0] rd_mux;

    assign page_ok = (i_req.page == radb_pkg::RADB_PAGE_ZERO);
    assign slice_hit = page_ok && (i_req.addr >= radb_pkg::RADB_OFF_NOISE_DEB);

    // RULE1 noise field store
    // Only low five bits are writable; reserved bits stay zero
    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            noise_code_reg <= radb_pkg::RADB_NOISE_CODE_RST;
        end else if (i_req.wr_en && page_ok && (i_req.addr == radb_pkg::RADB_OFF_NOISE_DEB)) begin
            noise_code_reg <= i_req.wdata[4:0];
        end
    end

    // RULE4 signal field store
    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            signal_code_reg <= radb_pkg::RADB_SIGNAL_CODE_RST;
        end else if (i_req.wr_en && page_ok && (i_req.addr == radb_pkg::RADB_OFF_SIGNAL_DEB)) begin
            signal_code_reg <= i_req.wdata[3:0];
        end
    end

    // RULE9 status ignores writes
    // RULE8 clamped signed gain
    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            gain_stat_reg <= radb_pkg::RADB_GAIN_STAT_RST;
        end else begin
            gain_stat_reg <= clamp_gain(i_gain_applied);
        end
    end

    // RULE7 read back of status
    always_comb begin
        rd_mux = 8'h00;
        case (i_req.addr)
            radb_pkg::RADB_OFF_NOISE_DEB: rd_mux = {3'b000, noise_code_reg};
            radb_pkg::RADB_OFF_SIGNAL_DEB: rd_mux = {4'h0, signal_code_reg};
            radb_pkg::RADB_OFF_GAIN_STAT: rd_mux = gain_stat_reg;
            default: rd_mux = 8'h00;
        endcase
    end

    // Registered read answer, one cycle after the request
    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            o_rd_data <= 8'h00;
            o_rd_valid <= 1'b0;
        end else begin
            o_rd_valid <= i_req.rd_en && slice_hit;
            if (i_req.rd_en && slice_hit) begin
                o_rd_data <= rd_mux;
            end
        end
    end

    // ----------------------------------------------------------------
    // Noise mode decision
    // ----------------------------------------------------------------
    radb_pkg::radb_state_t state_reg;
    logic detect_en;
    logic noise_run;
    logic signal_run;
    logic noise_done;
    logic signal_done;
    logic [16:0] noise_target;
    logic [16:0] signal_target;

    // RULE12 threshold zero disables
    assign detect_en = (i_noise_thresh != radb_pkg::RADB_THRESH_OFF);
    // RULE2 RULE3 noise decode
    assign noise_target = noise_periods(noise_code_reg);
    // RULE5 RULE6 signal decode
    assign signal_target = signal_periods(signal_code_reg);
    assign noise_run = detect_en && (state_reg == radb_pkg::RADB_ST_SIGNAL) && i_below_thresh;
    assign signal_run = detect_en && (state_reg == radb_pkg::RADB_ST_NOISE) && !i_below_thresh;

    radb_debounce_timer #(.CNT_W(radb_pkg::RADB_CNT_W)) u_noise_tmr (
        .i_mclk(i_mclk),
        .i_srst(i_srst),
        .i_run(noise_run),
        .i_tick(i_fs_tick),
        .i_target(noise_target),
        .o_done(noise_done)
    );

    radb_debounce_timer #(.CNT_W(radb_pkg::RADB_CNT_W)) u_signal_tmr (
        .i_mclk(i_mclk),
        .i_srst(i_srst),
        .i_run(signal_run),
        .i_tick(i_fs_tick),
        .i_target(signal_target),
        .o_done(signal_done)
    );

    // RULE14 debounced mode changes
    always_ff @(posedge i_mclk) begin
        if (i_srst || !detect_en) begin
            state_reg <= radb_pkg::RADB_ST_SIGNAL;
        end else begin
            case (state_reg)
                radb_pkg::RADB_ST_SIGNAL: begin
                    if (noise_done) begin
                        state_reg <= radb_pkg::RADB_ST_NOISE;
                    end
                end
                radb_pkg::RADB_ST_NOISE: begin
                    if (signal_done) begin
                        state_reg <= radb_pkg::RADB_ST_SIGNAL;
                    end
                end
                default: state_reg <= radb_pkg::RADB_ST_SIGNAL;
            endcase
        end
    end

    assign o_noise_mode = (state_reg == radb_pkg::RADB_ST_NOISE);

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_srst);

    a_noise_short_map: assert property ( // RULE1
        (noise_code_reg == 5'h04)
            |-> (noise_target == 17'h0_0020 && noise_periods(5'h01) == 17'h0_0004))
        else $error("noise short code decodes wrong");
    a_noise_mid_map: assert property ( // RULE2
        (noise_code_reg == 5'h07)
            |-> (noise_target == 17'h0_0100 && noise_periods(5'h0A) == 17'h0_2000))
        else $error("noise mid code decodes wrong");
    a_noise_long_map: assert property ( // RULE3
        (noise_code_reg == 5'h1F)
            |-> (noise_target == 17'h1_5000 && noise_periods(5'h1E) == 17'h1_4000))
        else $error("noise long code decodes wrong");
    a_signal_short_map: assert property ( // RULE4
        (signal_code_reg == 4'h4)
            |-> (signal_target == 17'h0_0020 && signal_periods(4'h1) == 17'h0_0004))
        else $error("signal short code decodes wrong");
    a_signal_mid_map: assert property ( // RULE5
        (signal_code_reg == 4'h9)
            |-> (signal_target == 17'h0_0800 && signal_periods(4'h8) == 17'h0_0400))
        else $error("signal mid code decodes wrong");
    a_signal_long_map: assert property ( // RULE6
        (signal_code_reg == 4'hD) |-> (signal_target == 17'h0_2800))
        else $error("signal long code decodes wrong");
    a_gain_follows_input: assert property ( // RULE7
        ($signed(i_gain_applied) >= 0 && $signed(i_gain_applied) <= 80)
            |=> (gain_stat_reg == $past(i_gain_applied)))
        else $error("gain status does not follow gain");
    a_gain_neg_clamp: assert property ( // RULE8
        ($signed(i_gain_applied) < -24) |=> (gain_stat_reg == 8'hE8))
        else $error("negative gain not clamped to -12 dB");
    a_status_write_ignored: assert property ( // RULE9
        (i_req.wr_en && page_ok && i_req.addr == 7'h65 && $stable(i_gain_applied))
            |=> $stable(gain_stat_reg))
        else $error("write changed gain status");
    a_thresh_off_quiet: assert property ( // RULE12
        (i_noise_thresh == 5'h00) |=> !o_noise_mode)
        else $error("noise mode with detection off");
    a_enter_after_debounce: assert property ( // RULE14
        $rose(o_noise_mode) |-> $past(noise_done) && $past(i_below_thresh))
        else $error("noise mode entered without debounce");
    a_leave_after_debounce: assert property ( // RULE14
        ($fell(o_noise_mode) && $past(detect_en) && detect_en && !$past(i_srst))
            |-> $past(signal_done))
        else $error("noise mode left without debounce");

    c_enter_noise: cover property ($rose(o_noise_mode));
    c_leave_noise: cover property ($fell(o_noise_mode) && detect_en);
    c_status_read: cover property (i_req.rd_en && page_ok && i_req.addr == 7'h65 ##1 o_rd_valid);

endmodule

/* File: verilog/radb_top_note_unused.sv */
// Purpose: holds no logic; the slice is radb_top with radb_debounce_timer
// Assumes: nothing
// Notes: left without a module so that the design keeps two modules

/* File: testbench/radb_host_model.sv */
// Purpose: host model issuing decoded register accesses to the slice
// Assumes: one access at a time, launched just after a clock edge
// Notes: read data is taken one cycle after the request edge
`timescale 1ns/1ps
module radb_host_model (
    input wire logic i_mclk,
    input wire logic [7:0] i_rd_data,
    input wire logic i_rd_valid,
    output radb_pkg::radb_req_t o_req
);
    // ----------------------------------------------------------------
    // Access tasks
    // ----------------------------------------------------------------
    // Bus idle from time zero
    initial begin
        o_req = '0;
    end

    // Single byte write, page zero only
    task automatic wr(input logic [6:0] addr, input logic [7:0] data);
        radb_pkg::radb_req_t rq;
        rq = '0;
        if (addr >= radb_pkg::RADB_OFF_RSVD_FIRST) begin
            return;
        end
        rq.wr_en = 1'b1;
        rq.page = radb_pkg::RADB_PAGE_ZERO;
        rq.addr = addr;
        rq.wdata = data;
        if (addr == radb_pkg::RADB_OFF_NOISE_DEB) begin
            rq.wdata = {3'h0, data[4:0]};
        end else if (addr == radb_pkg::RADB_OFF_SIGNAL_DEB) begin
            rq.wdata = {4'h0, data[3:0]};
        end
        @(posedge i_mclk);
        o_req <= rq;
        @(posedge i_mclk);
        o_req <= '0;
    endtask

    // Single byte read; page given so a refused access can be tried
    task automatic rd(input logic [7:0] page, input logic [6:0] addr,
                      output logic [7:0] data, output logic ok);
        radb_pkg::radb_req_t rq;
        rq = '0;
        rq.rd_en = 1'b1;
        rq.page = page;
        rq.addr = addr;
        @(posedge i_mclk);
        o_req <= rq;
        @(posedge i_mclk);
        o_req <= '0;
        #1;
        ok = i_rd_valid;
        data = i_rd_data;
    endtask
endmodule

/* File: testbench/radb_top_tb.sv */
// Purpose: self-checking bench for the right AGC debounce slice
// Assumes: sample tick mostly held high so debounce counts run one per cycle
// Notes: expected codes and times come from an integer model here
`timescale 1ns/1ps
module radb_top_tb;
    logic mclk;
    logic srst;
    radb_pkg::radb_req_t req;
    logic fs_tick;
    logic below;
    logic [4:0] thresh;
    logic [7:0] gain;
    logic [7:0] rd_data;
    logic rd_valid;
    logic noise_mode;
    int err_total = 0;
    int samples_checked = 0;
    int cycles = 0;
    int nc[7] = '{0, 1, 2, 3, 4, 7, 10};
    int sc[7] = '{0, 1, 4, 8, 9, 13, 3};
    logic [7:0] gl[9] = '{8'hE8, 8'hE9, 8'hFF, 8'h00, 8'h01, 8'h4F, 8'h50, 8'h80, 8'h7F};
    logic [7:0] lf = 8'h42;
    logic [7:0] d;
    logic ok;

    radb_top u_dut (.i_mclk(mclk), .i_srst(srst), .i_req(req), .i_fs_tick(fs_tick),
        .i_below_thresh(below), .i_noise_thresh(thresh), .i_gain_applied(gain),
        .o_rd_data(rd_data), .o_rd_valid(rd_valid), .o_noise_mode(noise_mode));
    radb_host_model u_host (.i_mclk(mclk), .i_rd_data(rd_data), .i_rd_valid(rd_valid),
        .o_req(req));

    // ----------------------------------------------------------------
    // Clock, timeout and helpers
    // ----------------------------------------------------------------
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // Cut a hang short
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 40000) begin
            err_total++;
            wrap_up();
        end
    end

    function automatic logic [7:0] lfsr_next(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    // Debounce periods per code, integer model
    function automatic int noise_n(input int c);
        if (c <= 7) return (c == 0) ? 0 : 2 << c;
        if (c <= 9) return 1 << (c + 2);
        if (c <= 11) return 8192;
        return (c - 10) * 4096;
    endfunction
    function automatic int signal_n(input int c);
        if (c <= 6) return (c == 0) ? 0 : 2 << c;
        if (c <= 9) return 1 << (c + 2);
        return (c - 8) * 2048;
    endfunction

    // Reported gain, held to the reportable range
    function automatic logic [7:0] gain_exp(input logic [7:0] g);
        int v;
        v = int'($signed(g));
        if (v > 80) return radb_pkg::RADB_GAIN_MAX;
        if (v < -24) return radb_pkg::RADB_GAIN_MIN;
        return g;
    endfunction

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %0t %s got %0h exp %0h", $time, what, got, exp);
        end
    endtask

    task automatic rd_check(input logic [6:0] addr, input logic [7:0] exp);
        u_host.rd(8'h00, addr, d, ok);
        check({31'h0, ok}, 32'h1, "read valid");
        check({24'h0, d}, {24'h0, exp}, "read data");
    endtask

    // Edges from the level change until the mode follows it
    task automatic settle(input logic lvl, input int n);
        int cnt;
        cnt = 0;
        @(posedge mclk);
        below <= lvl;
        do begin
            @(posedge mclk);
            #1;
            cnt++;
        end while (noise_mode !== lvl && cnt < n + 8);
        check(cnt, n + 1, "debounce time");
    endtask

    task automatic wrap_up();
        $display("checked %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        srst = 1'b1;
        fs_tick = 1'b1;
        below = 1'b0;
        thresh = 5'h05;
        gain = 8'h00;
        repeat (12) @(posedge mclk);
        srst <= 1'b0;
        rd_check(radb_pkg::RADB_OFF_NOISE_DEB, 8'h00);
        rd_check(radb_pkg::RADB_OFF_SIGNAL_DEB, 8'h00);
        rd_check(radb_pkg::RADB_OFF_GAIN_STAT, 8'h00);
        $display("test reset done");
        // Widest codes, reserved bits read back zero
        u_host.wr(radb_pkg::RADB_OFF_NOISE_DEB, 8'hFE);
        rd_check(radb_pkg::RADB_OFF_NOISE_DEB, 8'h1E);
        u_host.wr(radb_pkg::RADB_OFF_NOISE_DEB, 8'hFF);
        rd_check(radb_pkg::RADB_OFF_NOISE_DEB, 8'h1F);
        u_host.wr(radb_pkg::RADB_OFF_SIGNAL_DEB, 8'hFF);
        rd_check(radb_pkg::RADB_OFF_SIGNAL_DEB, 8'h0F);
        rd_check(7'h70, 8'h00);
        u_host.rd(8'h01, radb_pkg::RADB_OFF_NOISE_DEB, d, ok);
        check({31'h0, ok}, 32'h0, "other page");
        $display("test access done");
        for (int i = 0; i < 7; i++) begin
            u_host.wr(radb_pkg::RADB_OFF_NOISE_DEB, nc[i][7:0]);
            u_host.wr(radb_pkg::RADB_OFF_SIGNAL_DEB, sc[i][7:0]);
            rd_check(radb_pkg::RADB_OFF_NOISE_DEB, nc[i][7:0]);
            rd_check(radb_pkg::RADB_OFF_SIGNAL_DEB, sc[i][7:0]);
            settle(1'b1, noise_n(nc[i]));
            settle(1'b0, signal_n(sc[i]));
        end
        $display("test debounce done");
        // Ticks on every other cycle only: four ticks take eight cycles
        u_host.wr(radb_pkg::RADB_OFF_NOISE_DEB, 8'h01);
        @(posedge mclk);
        below <= 1'b1;
        fs_tick <= 1'b0;
        for (int k = 0; k < 8; k++) begin
            @(posedge mclk);
            fs_tick <= ~fs_tick;
        end
        #1;
        check({31'h0, noise_mode}, 32'h0, "tick count early");
        @(posedge mclk);
        fs_tick <= 1'b1;
        #1;
        check({31'h0, noise_mode}, 32'h1, "tick count");
        settle(1'b0, signal_n(3));
        $display("test tick done");
        // Detection off drops noise mode and holds it down
        settle(1'b1, noise_n(1));
        @(posedge mclk);
        thresh <= radb_pkg::RADB_THRESH_OFF;
        repeat (2) @(posedge mclk);
        #1;
        check({31'h0, noise_mode}, 32'h0, "thresh off");
        repeat (40) @(posedge mclk);
        #1;
        check({31'h0, noise_mode}, 32'h0, "thresh off hold");
        @(posedge mclk);
        below <= 1'b0;
        thresh <= 5'h05;
        $display("test detect off done");
        for (int i = 0; i < 13; i++) begin
            lf = lfsr_next(lf);
            @(posedge mclk);
            gain <= (i < 9) ? gl[i] : 8'(int'(lf) % 105 - 24);
            repeat (3) @(posedge mclk);
            rd_check(radb_pkg::RADB_OFF_GAIN_STAT, gain_exp(gain));
            u_host.wr(radb_pkg::RADB_OFF_GAIN_STAT, ~gain);
            rd_check(radb_pkg::RADB_OFF_GAIN_STAT, gain_exp(gain));
        end
        $display("test gain done");
        wrap_up();
    end
endmodule
